/* File: design/gpx_port.sv */
`timescale 1ns/1ps
`include "gpx_cfg.svh"
// What this block does
// R1 - input pin: data read returns pin level
// R2 - option bit picks input/output flavour
// R3 - input mode: data write only updates latch
// R4 - six pins, one pin output only
// R5 - register bit X maps to pin X
// R6 - interrupt pins raise requests per sensitivity
// R7 - pins sharing a vector are ANDed
// R8 - vector fetch clears pending request
// R9 - sensitivity change clears pending request
// R10 - disabled interrupt forces detector input high
// R11 - software enables interrupts in safe order
// R12 - software disables interrupts in safe order
// R13 - output pin: latch drives, read returns latch
// R14 - zero drives low; one high or floats
// R15 - software writes latch before turning output
// R16 - peripheral output overrides port settings
// R17 - peripheral input: pin still readable
// R18 - shared peripheral pin stays floating input
// R19 - pull-up and high driver only where due
// R20 - input with alternate output reads alternate
// R21 - output with alternate input sees latch
// R22 - pins synchronised before use
module gpx_port #(
   parameter int N_PINS = 6,
   parameter int OUT_ONLY_PIN = 3,
   parameter int N_VEC = 5,
   parameter int ADDR_W = 8,
   parameter logic [N_PINS*`GPX_MAP_W-1:0] VEC_MAP = `GPX_VEC_MAP
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [N_PINS-1:0] pad_in,
   output logic [N_PINS-1:0] pad_out,
   output logic [N_PINS-1:0] pad_oe,
   output logic [N_PINS-1:0] pad_pullup_en,
   output logic [N_PINS-1:0] pad_hi_drv_en,
   input wire logic [N_PINS-1:0] alt_out_en,
   input wire logic [N_PINS-1:0] alt_out,
   input wire logic [N_PINS-1:0] alt_open_drain,
   output logic [N_PINS-1:0] alt_in,
   input wire logic [N_VEC-1:0] irq_ack,
   output logic [N_VEC-1:0] irq_req
);
   // sizes the logic cannot serve are refused while elaborating
   if (N_PINS < 1 || N_PINS > 8 || OUT_ONLY_PIN < 0 || OUT_ONLY_PIN >= N_PINS) begin : g_bad_pins
      $error("gpx_port: pin count or output-only pin out of range");
   end
   if (N_VEC < 1 || N_VEC * `GPX_SENS_W > 32 || ADDR_W < 5) begin : g_bad_vec
      $error("gpx_port: vector count or address width out of range");
   end

   // ****************************************
   // configuration and state
   // ****************************************
   logic [N_PINS-1:0] data_q;
   logic [N_PINS-1:0] dir_q;
   logic [N_PINS-1:0] opt_q;
   logic [N_VEC*`GPX_SENS_W-1:0] sens_q;
   logic [N_VEC*`GPX_SENS_W-1:0] sens_d;
   logic [N_VEC-1:0] pend_q;
   logic [N_VEC-1:0] level_q;
   logic [N_VEC-1:0] level_d;
   logic [N_VEC-1:0] event_d;
   logic [N_PINS-1:0] pin_s;
   logic [N_PINS-1:0] int_en;
   logic [N_PINS-1:0] rd_data;
   logic [N_PINS-1:0] out_mode;
   logic [N_PINS-1:0] push_pull;
   logic [N_PINS-1:0] out_val;

   // R22 two-stage sync
   gpx_sync #(
      .W(N_PINS)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .din(pad_in),
      .dout(pin_s)
   );

   // ****************************************
   // register bus, write side
   // ****************************************
   logic aw_got_q;
   logic w_got_q;
   logic aw_ok_q;
   gpx_pkg::gpx_idx_t aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic awready_q;
   logic wready_q;
   gpx_pkg::gpx_resp_t bresp_q;
   logic aw_hs;
   logic w_hs;
   logic b_hs;
   logic do_write;
   logic [31:0] wmask;

   assign aw_hs = s_axi_awvalid & awready_q;
   assign w_hs = s_axi_wvalid & wready_q;
   assign b_hs = bvalid_q & s_axi_bready;
   assign do_write = aw_got_q & w_got_q & ~bvalid_q;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a >> (`GPX_IDX_MSB + 1)) == '0 && a[`GPX_IDX_MSB:`GPX_IDX_LSB] <= `GPX_IDX_LAST;
   endfunction : addr_ok

   // address and data are taken in either order, then answered together
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_ok_q <= 1'b0;
         aw_idx_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `GPX_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_got_q <= 1'b1;
            aw_ok_q <= addr_ok(s_axi_awaddr);
            aw_idx_q <= s_axi_awaddr[`GPX_IDX_MSB:`GPX_IDX_LSB];
         end else if (b_hs) begin
            aw_got_q <= 1'b0;
         end
         if (w_hs) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (b_hs) begin
            w_got_q <= 1'b0;
         end
         awready_q <= ~aw_hs & (b_hs | (~aw_got_q & ~bvalid_q));
         wready_q <= ~w_hs & (b_hs | (~w_got_q & ~bvalid_q));
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_ok_q ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
         end else if (b_hs) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ****************************************
   // port registers
   // ****************************************
   logic wr_data;
   logic wr_dir;
   logic wr_opt;
   logic wr_sens;
   assign wr_data = do_write & aw_ok_q & aw_idx_q == `GPX_IDX_DATA & wstrb_q[0];
   assign wr_dir = do_write & aw_ok_q & aw_idx_q == `GPX_IDX_DIR & wstrb_q[0];
   assign wr_opt = do_write & aw_ok_q & aw_idx_q == `GPX_IDX_OPT & wstrb_q[0];
   assign wr_sens = do_write & aw_ok_q & aw_idx_q == `GPX_IDX_SENS;

   always_comb begin
      sens_d = sens_q;
      if (wr_sens) begin
         sens_d = (sens_q & ~wmask[N_VEC*`GPX_SENS_W-1:0])
                | (wdata_q[N_VEC*`GPX_SENS_W-1:0] & wmask[N_VEC*`GPX_SENS_W-1:0]);
      end
   end

   // R3 latch written in any direction
   // R5 bit x is pin x
   always_ff @(posedge clk) begin
      if (srst) begin
         data_q <= N_PINS'(`GPX_RST_DATA);
      end else if (wr_data) begin
         data_q <= wdata_q[N_PINS-1:0];
      end
   end

   // R4 output-only pin stays an output
   always_ff @(posedge clk) begin
      if (srst) begin
         dir_q <= N_PINS'(`GPX_RST_DIR);
      end else if (wr_dir) begin
         dir_q <= wdata_q[N_PINS-1:0];
         dir_q[OUT_ONLY_PIN] <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         opt_q <= N_PINS'(`GPX_RST_OPT);
      end else if (wr_opt) begin
         opt_q <= wdata_q[N_PINS-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sens_q <= (N_VEC*`GPX_SENS_W)'(`GPX_RST_SENS);
      end else begin
         sens_q <= sens_d;
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   always_comb begin
      for (int p = 0; p < N_PINS; p++) begin
         // R16 peripheral output wins
         out_mode[p] = alt_out_en[p] | dir_q[p];
         // R2 option picks push-pull
         push_pull[p] = alt_out_en[p] ? ~alt_open_drain[p] : opt_q[p];
         out_val[p] = alt_out_en[p] ? alt_out[p] : data_q[p];
         // R2 option with input enables interrupt
         int_en[p] = ~dir_q[p] & opt_q[p] & ~alt_out_en[p] & (p != OUT_ONLY_PIN);
         // R13 output reads latch
         // R20 alternate output read back
         // R1 input reads pin
         // R17 peripheral input readable
         if (dir_q[p]) begin
            rd_data[p] = data_q[p];
         end else if (alt_out_en[p]) begin
            rd_data[p] = alt_out[p];
         end else begin
            rd_data[p] = pin_s[p];
         end
      end
   end

   // pad controls are registered, so they trail the registers by one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         pad_out <= '0;
         pad_oe <= '0;
         pad_pullup_en <= '0;
         pad_hi_drv_en <= '0;
         alt_in <= '0;
      end else begin
         pad_out <= out_val;
         // R14 low always driven, high only push-pull
         pad_oe <= out_mode & (~out_val | push_pull);
         // R19 pull-up in pull-up input only
         pad_pullup_en <= ~out_mode & opt_q;
         // R19 high driver in push-pull only
         pad_hi_drv_en <= out_mode & push_pull;
         // R21 peripheral sees latch on output pin
         alt_in <= (dir_q & data_q) | (~dir_q & pin_s);
      end
   end

   // ****************************************
   // external interrupt detection
   // ****************************************
   always_comb begin
      for (int v = 0; v < N_VEC; v++) begin
         level_d[v] = 1'b1;
         for (int p = 0; p < N_PINS; p++) begin
            // R10 disabled pin forced high
            // R7 shared vector ANDed
            if (VEC_MAP[p*`GPX_MAP_W +: `GPX_MAP_W] == `GPX_MAP_W'(v) && int_en[p]) begin
               level_d[v] = level_d[v] & pin_s[p];
            end
         end
         // R6 event per sensitivity
         case (sens_q[v*`GPX_SENS_W +: `GPX_SENS_W])
            `GPX_SENS_FALL_LOW: event_d[v] = ~level_d[v];
            `GPX_SENS_RISE: event_d[v] = level_d[v] & ~level_q[v];
            `GPX_SENS_FALL: event_d[v] = ~level_d[v] & level_q[v];
            `GPX_SENS_BOTH: event_d[v] = level_d[v] ^ level_q[v];
            default: event_d[v] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         level_q <= '1;
      end else begin
         level_q <= level_d;
      end
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         pend_q <= '0;
      end else begin
         for (int v = 0; v < N_VEC; v++) begin
            if (event_d[v]) begin
               pend_q[v] <= 1'b1;
            // R8 cleared on vector fetch
            // R9 cleared on sensitivity change
            end else if (irq_ack[v] ||
                         sens_d[v*`GPX_SENS_W +: `GPX_SENS_W] !=
                         sens_q[v*`GPX_SENS_W +: `GPX_SENS_W]) begin
               pend_q[v] <= 1'b0;
            end
         end
      end
   end

   assign irq_req = pend_q;

   // ****************************************
   // register bus, read side
   // ****************************************
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   gpx_pkg::gpx_resp_t rresp_q;
   logic [31:0] rd_mux;
   logic ar_hs;

   assign ar_hs = s_axi_arvalid & arready_q;

   always_comb begin
      rd_mux = '0;
      case (s_axi_araddr[`GPX_IDX_MSB:`GPX_IDX_LSB])
         `GPX_IDX_DATA: rd_mux[N_PINS-1:0] = rd_data;
         `GPX_IDX_DIR: rd_mux[N_PINS-1:0] = dir_q;
         `GPX_IDX_OPT: rd_mux[N_PINS-1:0] = opt_q;
         `GPX_IDX_SENS: rd_mux[N_VEC*`GPX_SENS_W-1:0] = sens_q;
         `GPX_IDX_PEND: rd_mux[N_VEC-1:0] = pend_q;
         default: rd_mux = '0;
      endcase
      if (!addr_ok(s_axi_araddr)) begin
         rd_mux = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `GPX_RESP_OKAY;
      end else begin
         if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= addr_ok(s_axi_araddr) ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end else if (!rvalid_q) begin
            arready_q <= 1'b1;
         end
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule : gpx_port

/* File: common/gpx_cfg.svh */
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

// ****************************************
// register indexes (byte address = 4 x index)
// ****************************************
`define GPX_IDX_DATA 3'h0
`define GPX_IDX_DIR 3'h1
`define GPX_IDX_OPT 3'h2
`define GPX_IDX_SENS 3'h3
`define GPX_IDX_PEND 3'h4
`define GPX_IDX_LAST 3'h4
`define GPX_IDX_LSB 2
`define GPX_IDX_MSB 4

// ****************************************
// reset values
// ****************************************
`define GPX_RST_DATA 8'h00
`define GPX_RST_DIR 8'h08
`define GPX_RST_OPT 8'h02
`define GPX_RST_SENS 32'h0000_0000

// ****************************************
// sensitivity codes, two bits per vector
// ****************************************
`define GPX_SENS_W 2
`define GPX_SENS_FALL_LOW 2'h0
`define GPX_SENS_RISE 2'h1
`define GPX_SENS_FALL 2'h2
`define GPX_SENS_BOTH 2'h3

// ****************************************
// pin to vector map, three bits per pin
// ****************************************
`define GPX_MAP_W 3
`define GPX_VEC_MAP 18'h2_3e88

// ****************************************
// bus answers
// ****************************************
`define GPX_RESP_OKAY 2'h0
`define GPX_RESP_SLVERR 2'h2

`endif

/* File: common/gpx_pkg.sv */
package gpx_pkg;
   typedef logic [1:0] gpx_sens_t;
   typedef logic [2:0] gpx_idx_t;
   typedef logic [1:0] gpx_resp_t;
endpackage : gpx_pkg

/* File: design/gpx_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage is visible outside
module gpx_sync #(
   parameter int W = 6
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule : gpx_sync

/* File: test/gpx_pads_model.sv */
`timescale 1ns/1ps
module gpx_pads_model (
   input wire logic clk,
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe,
   input wire logic [5:0] pad_pullup_en,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   output logic [5:0] pad_in
);
   // ****************************************
   // pad level resolution
   // ****************************************
   logic [5:0] float_q = 6'h00;
   // undriven pads wander, so a stale level never passes for a real one
   always @(posedge clk) begin
      float_q <= ~pad_in;
   end
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pad_pullup_en | float_q));
endmodule : gpx_pads_model

/* File: test/gpx_port_assertions.sv */
`timescale 1ns/1ps
`include "gpx_cfg.svh"
module gpx_port_checker #(
   parameter int N_PINS = 6,
   parameter int N_VEC = 5,
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [N_PINS-1:0] pad_in,
   input wire logic [N_PINS-1:0] pad_out,
   input wire logic [N_PINS-1:0] pad_oe,
   input wire logic [N_PINS-1:0] pad_pullup_en,
   input wire logic [N_PINS-1:0] pad_hi_drv_en,
   input wire logic [N_PINS-1:0] alt_out_en,
   input wire logic [N_PINS-1:0] alt_out,
   input wire logic [N_PINS-1:0] alt_open_drain,
   input wire logic [N_VEC-1:0] irq_ack,
   input wire logic [N_VEC-1:0] irq_req
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (srst);
   logic [N_PINS-1:0] alt_drv;
   logic [N_PINS-1:0] alt_flt;
   assign alt_drv = alt_out_en & ~(alt_open_drain & alt_out);
   assign alt_flt = alt_out_en & alt_open_drain & alt_out;
   sequence pin0_quiet;
      pad_in[0] [*4];
   endsequence
   sequence ack_hit;
      irq_ack[0] && irq_req[0];
   endsequence
   // ****************************************
   // checks
   // ****************************************
   wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while a response waits");
   rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while read data waits");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h14
      |=> s_axi_rresp == `GPX_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   pull_drv_a: assert property ((pad_pullup_en & pad_hi_drv_en) == '0)
      else $error("pull-up and high driver both on");
   hi_drv_oe_a: assert property ((pad_hi_drv_en & ~pad_oe) == '0)
      else $error("high driver on an undriven pad");
   alt_drive_a: assert property (|alt_drv |=>
      (pad_oe & $past(alt_drv)) == $past(alt_drv)
      && (pad_out & $past(alt_drv)) == ($past(alt_out) & $past(alt_drv)))
      else $error("peripheral output not on pad");
   alt_float_a: assert property (|alt_flt |=> (pad_oe & $past(alt_flt)) == '0)
      else $error("open-drain peripheral high still driven");
   ack_clear_a: assert property (pin0_quiet ##0 ack_hit |=> !irq_req[0])
      else $error("vector fetch left request pending");
endmodule : gpx_port_checker
bind gpx_port gpx_port_checker #(.N_PINS(N_PINS), .N_VEC(N_VEC), .ADDR_W(ADDR_W)) chk_u (.*);

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "gpx_cfg.svh"
module tb_top;
   logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
   logic [5:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_hi_drv_en, alt_in;
   logic [5:0] alt_out_en, alt_out, alt_open_drain, ext_en, ext_val;
   logic [4:0] irq_ack, irq_req;
   int fails, n_tests;
   gpx_port dut_u (.*);
   gpx_pads_model pads_u (.*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ****************************************
   // bus and compare helpers
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_done = 1'b0;
      bit w_done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (s_axi_awready && !aw_done) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w_done) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp_q = s_axi_bresp;
   endtask : wr
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      check(what, rd_q, exp);
   endtask : rdc
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rdc("data", 8'h00, 32'h0000_0000);
      rdc("dir", 8'h04, {24'h00_0000, `GPX_RST_DIR});
      rdc("opt", 8'h08, {24'h00_0000, `GPX_RST_OPT});
      rdc("sens", 8'h0c, `GPX_RST_SENS);
      rdc("unmapped", 8'h14, 32'h0000_0000);
      check("unmapped resp", resp_q, `GPX_RESP_SLVERR);
      check("level irq", irq_req[1], 1'b1);
      wr(8'h04, 32'h0000_0000);
      check("wr resp", resp_q, `GPX_RESP_OKAY);
      rdc("dir pin3", 8'h04, 32'h0000_0008);
      // lane 0 strobe off: the latch must keep its value
      s_axi_wstrb <= 4'he;
      wr(8'h00, 32'h0000_00ff);
      s_axi_wstrb <= 4'hf;
      wr(8'h14, 32'h0000_00ff);
      check("wr unmapped resp", resp_q, `GPX_RESP_SLVERR);
      rdc("data strobe", 8'h00, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_input;
      @(posedge clk);
      ext_val <= 6'h25;
      wr(8'h00, 32'h0000_003f);
      repeat (3) @(posedge clk);
      check("pad_oe input", pad_oe, 6'h00);
      check("pullup", pad_pullup_en, 6'h02);
      rdc("data input", 8'h00, 32'h0000_002d);
      $display("test input done");
   endtask : t_input
   task automatic t_output;
      @(posedge clk);
      ext_en <= 6'h00;
      wr(8'h00, 32'h0000_002a);
      wr(8'h08, 32'h0000_0015);
      wr(8'h04, 32'h0000_003f);
      repeat (2) @(posedge clk);
      check("oe mixed", pad_oe, 6'h15);
      check("hi drv", pad_hi_drv_en, 6'h15);
      check("pullup out", pad_pullup_en, 6'h00);
      check("pad_out", pad_out, 6'h2a);
      rdc("data output", 8'h00, 32'h0000_002a);
      wr(8'h00, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check("oe low", pad_oe, 6'h3f);
      $display("test output done");
   endtask : t_output
   task automatic t_alt;
      wr(8'h00, 32'h0000_0015);
      repeat (2) @(posedge clk);
      check("alt_in output", alt_in, 6'h15);
      wr(8'h08, 32'h0000_0000);
      wr(8'h04, 32'h0000_0000);
      @(posedge clk);
      ext_en <= 6'h3e;
      ext_val <= 6'h00;
      alt_out <= 6'h01;
      alt_out_en <= 6'h01;
      repeat (3) @(posedge clk);
      check("alt oe", pad_oe, 6'h09);
      rdc("alt read", 8'h00, 32'h0000_0001);
      check("alt_in input", alt_in, 6'h01);
      @(posedge clk);
      alt_open_drain <= 6'h01;
      repeat (2) @(posedge clk);
      check("alt od", pad_oe, 6'h08);
      @(posedge clk);
      alt_out_en <= 6'h00;
      alt_open_drain <= 6'h00;
      $display("test alternate done");
   endtask : t_alt
   task automatic t_irq;
      @(posedge clk);
      ext_en <= 6'h3f;
      wr(8'h0c, 32'h0000_0001);
      wr(8'h08, 32'h0000_0001);
      repeat (4) @(posedge clk);
      check("no spurious", irq_req[0], 1'b0);
      ext_val <= 6'h01;
      repeat (4) @(posedge clk);
      check("rise", irq_req[0], 1'b1);
      irq_ack <= 5'h1f;
      @(posedge clk);
      irq_ack <= 5'h00;
      @(posedge clk);
      check("ack", irq_req, 5'h00);
      ext_val <= 6'h00;
      repeat (4) @(posedge clk);
      wr(8'h0c, 32'h0000_0002);
      wr(8'h08, 32'h0000_0000);
      wr(8'h0c, 32'h0000_0001);
      wr(8'h0c, 32'h0000_0002);
      wr(8'h08, 32'h0000_0001);
      repeat (4) @(posedge clk);
      check("forced edge", irq_req[0], 1'b1);
      rdc("pend", 8'h10, 32'h0000_0001);
      wr(8'h0c, 32'h0000_0001);
      @(posedge clk);
      check("sens clear", irq_req[0], 1'b0);
      $display("test interrupt done");
   endtask : t_irq
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      srst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      s_axi_wstrb = 4'hf;
      {alt_out_en, alt_out, alt_open_drain, ext_val} = 24'h00_0000;
      ext_en = 6'h3f;
      irq_ack = 5'h00;
      fails = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_input();
      t_output();
      t_alt();
      t_irq();
      wrap_up();
   end
   // runs take well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      wrap_up();
   end
endmodule : tb_top
